/* File: logic/io_port_pkg.sv */
// constants for the four-port pin data path
package io_port_pkg;
  // register select codes on the internal bus (port in addr[5:4])
  localparam logic [3:0] REG_PIN_INPUT    = 4'h0;
  localparam logic [3:0] REG_PIN_OUTPUT   = 4'h1;
  localparam logic [3:0] REG_CELL_VALUE   = 4'h2;
  localparam logic [3:0] REG_CELL_BLOCK   = 4'h3;
  localparam logic [3:0] REG_INPUT_CELL   = 4'h4;
  localparam logic [3:0] REG_DRV_STATUS   = 4'h5;
  localparam logic [3:0] REG_DRIVE_SEL    = 4'h6;
  localparam logic [3:0] REG_DIRECTION    = 4'h7;
  localparam logic [3:0] REG_MODE_CTRL    = 4'h8;
  localparam logic [1:0] PORT_FIRST  = 2'h0;
  localparam logic [1:0] PORT_SECOND = 2'h1;
  localparam logic [1:0] PORT_THIRD  = 2'h2;
  localparam logic [1:0] PORT_FOURTH = 2'h3;
  localparam logic [7:0] RESET_BYTE  = 8'h00;
  // fourth port implements bits 2 and 1 only
  localparam logic [7:0] FOURTH_MASK = 8'h06;
  // upper nibble open drain, lower nibble fast slew on first two ports
  localparam logic [7:0] UPPER_NIB   = 8'hF0;
  localparam logic [7:0] LOWER_NIB   = 8'h0F;
  // third port pins 7 to 4 reserved for the test access port
  localparam logic [7:0] TEST_PINS   = 8'hF0;
  // third port pin that can carry the battery indicator
  localparam int         BATTERY_PIN = 4;
  // fourth port pin roles
  localparam int         SELECT_PIN  = 2;
  localparam int         CLOCK_PIN   = 1;
endpackage : io_port_pkg

/* File: logic/io_cell_bank.sv */
// eight logic-clocked output flip-flops with masked processor load
`timescale 1ns/1ps
module io_cell_bank #(
  parameter int WIDTH = 8
) (
  input  wire logic             clock,     // system clock
  input  wire logic             rst,       // sync reset, high
  input  wire logic             clk_rise,  // logic clock edge seen
  input  wire logic [WIDTH-1:0] logic_d,   // product-term next values
  input  wire logic             cpu_load,  // processor write strobe
  input  wire logic [WIDTH-1:0] cpu_d,     // processor write data
  input  wire logic [WIDTH-1:0] block,     // load block mask
  output logic      [WIDTH-1:0] q          // flip-flop outputs
);
  typedef struct packed {
    logic [WIDTH-1:0] q;
  } state_t;
  state_t state_reg;
  state_t state_next;

  always_comb
  begin
    state_next = state_reg;
    if (clk_rise)
      state_next.q = logic_d;
    if (cpu_load)
      state_next.q = (state_reg.q & block) | (cpu_d & ~block);
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign q = state_reg.q;
endmodule : io_cell_bank

/* File: logic/io_port_path.sv */
// data path and drive control of four general-purpose pin ports
`timescale 1ns/1ps
module io_port_path #(
  parameter int WIDTH = 8
) (
  input  wire logic             clock,          // 250 MHz system clock
  input  wire logic             rst,            // sync reset, high
  input  wire logic [5:0]       addr,           // port[5:4], register[3:0]
  input  wire logic             wr,             // processor write strobe
  input  wire logic             rd,             // processor read strobe
  input  wire logic [7:0]       wdata,          // processor write data
  output logic      [7:0]       rdata,          // read data, one cycle on
  input  wire logic [7:0]       pin_a_in,       // first port pin levels
  input  wire logic [7:0]       pin_b_in,       // second port pin levels
  input  wire logic [7:0]       pin_c_in,       // third port pin levels
  input  wire logic [7:0]       pin_d_in,       // fourth port pin levels
  output logic      [7:0]       pin_a_out,      // first port drive level
  output logic      [7:0]       pin_b_out,      // second port drive level
  output logic      [7:0]       pin_c_out,      // third port drive level
  output logic      [7:0]       pin_d_out,      // fourth port drive level
  output logic      [7:0]       pin_a_oe,       // first port output enable
  output logic      [7:0]       pin_b_oe,       // second port output enable
  output logic      [7:0]       pin_c_oe,       // third port output enable
  output logic      [7:0]       pin_d_oe,       // fourth port output enable
  output logic      [7:0]       pin_a_od,       // first port open drain
  output logic      [7:0]       pin_b_od,       // second port open drain
  output logic      [7:0]       pin_c_od,       // third port open drain
  output logic      [7:0]       pin_a_fast,     // first port fast slew
  output logic      [7:0]       pin_b_fast,     // second port fast slew
  output logic      [7:0]       pin_d_fast,     // fourth port fast slew
  input  wire logic [7:0]       oe_term_a,      // logic enable terms, first
  input  wire logic [7:0]       oe_term_b,      // logic enable terms, second
  input  wire logic [7:0]       oe_term_c,      // logic enable terms, third
  input  wire logic [7:0]       oe_term_d,      // logic enable terms, fourth
  input  wire logic [7:0]       bank1_d,        // first bank product terms
  input  wire logic [7:0]       bank2_d,        // second bank product terms
  input  wire logic             bank1_to_b,     // first bank to second port
  input  wire logic             bank2_to_c,     // second bank to third port
  input  wire logic [7:0]       bank1_pins,     // pins of port taking bank1
  input  wire logic [7:0]       bank2_pins,     // pins of port taking bank2
  input  wire logic [7:0]       low_address,    // latched address byte
  input  wire logic             periph_mode,    // peripheral mode, port one
  input  wire logic [7:0]       periph_data,    // peripheral data to pins
  input  wire logic             periph_drive,   // peripheral drive enable
  input  wire logic [7:0]       input_latch_en, // input cell capture enable
  input  wire logic             battery_route,  // route battery flag out
  input  wire logic             battery_on_flag,// main supply below battery
  input  wire logic             select_enable,  // fourth pin 2 is select
  output logic      [23:0]      input_cell_bus, // input cells to logic bus
  output logic      [7:0]       bank1_q,        // first bank outputs
  output logic      [7:0]       bank2_q,        // second bank outputs
  output logic                  memory_disable, // select high: decode off
  output logic                  pd_counter_clk  // logic clock to counter
);
  if (WIDTH != 8)
  begin : g_width_check
    $error("io_port_path serves eight-pin ports only");
  end

  typedef struct packed {
    logic [3:0][7:0] dout;
    logic [3:0][7:0] dir;
    logic [3:0][7:0] drv;
    logic [1:0][7:0] mode;
    logic [1:0][7:0] block;
    logic [2:0][7:0] icell;
    logic [3:0][7:0] oe;
    logic [3:0][7:0] pout;
    logic [7:0]      rdata;
    logic            clk_d;
    logic            clk_rise;
    logic            mem_off;
  } state_t;
  state_t state_reg;
  state_t state_next;

  logic [3:0][7:0] pins;
  logic [3:0][7:0] terms;
  logic [7:0]      cell_q [0:2];
  logic [1:0]      port;
  logic [3:0]      sel;
  logic            load1;
  logic            load2;

  assign pins  = {pin_d_in, pin_c_in, pin_b_in, pin_a_in};
  assign terms = {oe_term_d, oe_term_c, oe_term_b, oe_term_a};
  assign port  = addr[5:4];
  assign sel   = addr[3:0];
  // bank routing picks which port address loads each bank
  assign load1 = wr && !state_reg.mem_off &&
                 sel == io_port_pkg::REG_CELL_VALUE &&
                 port == (bank1_to_b ? io_port_pkg::PORT_SECOND
                                     : io_port_pkg::PORT_FIRST);
  assign load2 = wr && !state_reg.mem_off &&
                 sel == io_port_pkg::REG_CELL_VALUE &&
                 port == (bank2_to_c ? io_port_pkg::PORT_THIRD
                                     : io_port_pkg::PORT_SECOND);

  io_cell_bank #(.WIDTH(8)) u_bank1 (
    .clock    (clock),
    .rst      (rst),
    .clk_rise (state_reg.clk_rise),
    .logic_d  (bank1_d),
    .cpu_load (load1),
    .cpu_d    (wdata),
    .block    (state_reg.block[0]),
    .q        (bank1_q)
  );

  io_cell_bank #(.WIDTH(8)) u_bank2 (
    .clock    (clock),
    .rst      (rst),
    .clk_rise (state_reg.clk_rise),
    .logic_d  (bank2_d),
    .cpu_load (load2),
    .cpu_d    (wdata),
    .block    (state_reg.block[1]),
    .q        (bank2_q)
  );

  // cell contents visible at each port's macrocell location
  always_comb
  begin
    cell_q[0] = bank1_to_b ? io_port_pkg::RESET_BYTE : bank1_q;
    cell_q[1] = (bank1_to_b ? bank1_q : io_port_pkg::RESET_BYTE) |
                (bank2_to_c ? io_port_pkg::RESET_BYTE : bank2_q);
    cell_q[2] = bank2_to_c ? bank2_q : io_port_pkg::RESET_BYTE;
  end

  always_comb
  begin
    logic [7:0] en;
    logic [7:0] lvl;
    logic [1:0] bidx;
    en   = '0;
    lvl  = '0;
    bidx = '0;
    state_next = state_reg;
    // logic clock pin edge, sampled synchronously
    state_next.clk_d    = pins[3][io_port_pkg::CLOCK_PIN];
    state_next.clk_rise = pins[3][io_port_pkg::CLOCK_PIN] &
                          ~state_reg.clk_d;
    state_next.mem_off  = select_enable &
                          pins[3][io_port_pkg::SELECT_PIN];
    for (int p = 0; p < 4; p++)
    begin
      en  = state_reg.dir[p] | terms[p];
      lvl = state_reg.dout[p];
      if (p < 2)
        lvl = (lvl & ~state_reg.mode[p]) |
              (low_address & state_reg.mode[p]);
      if (p == 0 && periph_mode)
      begin
        lvl = periph_data;
        en  = {8{periph_drive}};
      end
      // cell outputs take over only the pins picked by the bank pin masks
      if (p == 1 && bank1_to_b)
        lvl = (lvl & ~bank1_pins) | (bank1_q & bank1_pins);
      if (p == 0 && !bank1_to_b)
        lvl = (lvl & ~bank1_pins) | (bank1_q & bank1_pins);
      if (p == 1 && !bank2_to_c)
        lvl = (lvl & ~bank2_pins) | (bank2_q & bank2_pins);
      if (p == 2)
      begin
        if (bank2_to_c)
          lvl = (lvl & ~bank2_pins) | (bank2_q & bank2_pins);
        en = en & ~io_port_pkg::TEST_PINS;
        if (battery_route)
        begin
          lvl[io_port_pkg::BATTERY_PIN] = battery_on_flag;
          en[io_port_pkg::BATTERY_PIN]  = 1'b1;
        end
      end
      if (p == 3)
      begin
        en  = en & io_port_pkg::FOURTH_MASK;
        lvl = lvl & io_port_pkg::FOURTH_MASK;
      end
      state_next.oe[p]   = en;
      state_next.pout[p] = lvl;
    end
    // input cells capture pins while their latch enable is high
    for (int p = 0; p < 3; p++)
      state_next.icell[p] = (state_reg.icell[p] & ~input_latch_en) |
                            (pins[p] & input_latch_en);
    if (wr && !state_reg.mem_off)
    begin
      case (sel)
        io_port_pkg::REG_PIN_OUTPUT:
          state_next.dout[port] = (port == io_port_pkg::PORT_FOURTH) ?
            (wdata & io_port_pkg::FOURTH_MASK) : wdata;
        io_port_pkg::REG_DIRECTION:
          state_next.dir[port] = (port == io_port_pkg::PORT_FOURTH) ?
            (wdata & io_port_pkg::FOURTH_MASK) : wdata;
        io_port_pkg::REG_DRIVE_SEL:
          state_next.drv[port] = (port == io_port_pkg::PORT_FOURTH) ?
            (wdata & io_port_pkg::FOURTH_MASK) : wdata;
        io_port_pkg::REG_MODE_CTRL:
          if (port < io_port_pkg::PORT_THIRD)
            state_next.mode[port[0]] = wdata;
        io_port_pkg::REG_CELL_BLOCK:
          if (port != io_port_pkg::PORT_FOURTH)
          begin
            // second port writes the mask of each bank routed to it; first and third ports always write their own bank's mask
            if (port == io_port_pkg::PORT_FIRST ||
                (port == io_port_pkg::PORT_SECOND && bank1_to_b))
              state_next.block[0] = wdata;
            if (port == io_port_pkg::PORT_THIRD ||
                (port == io_port_pkg::PORT_SECOND && !bank2_to_c))
              state_next.block[1] = wdata;
          end
        default:
          state_next.dout = state_reg.dout;
      endcase
    end
    state_next.rdata = io_port_pkg::RESET_BYTE;
    if (rd && !state_reg.mem_off)
    begin
      bidx = (port == io_port_pkg::PORT_FIRST ||
              (port == io_port_pkg::PORT_SECOND && bank1_to_b)) ?
             2'h0 : 2'h1;
      case (sel)
        io_port_pkg::REG_PIN_INPUT:
          state_next.rdata = (port == io_port_pkg::PORT_FOURTH) ?
            (pins[port] & io_port_pkg::FOURTH_MASK) : pins[port];
        io_port_pkg::REG_PIN_OUTPUT:
          state_next.rdata = state_reg.dout[port];
        io_port_pkg::REG_DIRECTION:
          state_next.rdata = state_reg.dir[port];
        io_port_pkg::REG_DRIVE_SEL:
          state_next.rdata = state_reg.drv[port];
        io_port_pkg::REG_MODE_CTRL:
          if (port < io_port_pkg::PORT_THIRD)
            state_next.rdata = state_reg.mode[port[0]];
        io_port_pkg::REG_CELL_VALUE:
          if (port != io_port_pkg::PORT_FOURTH)
            state_next.rdata = cell_q[port];
        io_port_pkg::REG_CELL_BLOCK:
          if (port != io_port_pkg::PORT_FOURTH)
            state_next.rdata = state_reg.block[bidx[0]];
        io_port_pkg::REG_INPUT_CELL:
          if (port != io_port_pkg::PORT_FOURTH)
            state_next.rdata = state_reg.icell[port];
        io_port_pkg::REG_DRV_STATUS:
          if (port != io_port_pkg::PORT_FOURTH)
            state_next.rdata = state_reg.oe[port];
        default:
          state_next.rdata = io_port_pkg::RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign rdata          = state_reg.rdata;
  assign pin_a_out      = state_reg.pout[0];
  assign pin_b_out      = state_reg.pout[1];
  assign pin_c_out      = state_reg.pout[2];
  assign pin_d_out      = state_reg.pout[3];
  assign pin_a_oe       = state_reg.oe[0];
  assign pin_b_oe       = state_reg.oe[1];
  assign pin_c_oe       = state_reg.oe[2];
  assign pin_d_oe       = state_reg.oe[3];
  assign pin_a_od       = state_reg.drv[0] & io_port_pkg::UPPER_NIB;
  assign pin_b_od       = state_reg.drv[1] & io_port_pkg::UPPER_NIB;
  assign pin_c_od       = state_reg.drv[2];
  assign pin_a_fast     = state_reg.drv[0] & io_port_pkg::LOWER_NIB;
  assign pin_b_fast     = state_reg.drv[1] & io_port_pkg::LOWER_NIB;
  assign pin_d_fast     = state_reg.drv[3];
  assign input_cell_bus = state_reg.icell;
  assign memory_disable = state_reg.mem_off;
  assign pd_counter_clk = state_reg.clk_rise;
endmodule : io_port_path

/* File: tb/io_port_assertions.sv */
// checker for the pin data path register and drive rules
`timescale 1ns/1ps
module io_port_assertions (
  input wire logic       clock,          // system clock
  input wire logic       rst,            // sync reset
  input wire logic [5:0] addr,           // register address
  input wire logic       wr,             // write strobe
  input wire logic       rd,             // read strobe
  input wire logic [7:0] wdata,          // write data
  input wire logic [7:0] rdata,          // read data
  input wire logic [7:0] pin_d_in,       // fourth port pins
  input wire logic [7:0] pin_a_oe,       // first port enable
  input wire logic [7:0] pin_c_oe,       // third port enable
  input wire logic [7:0] pin_d_oe,       // fourth port enable
  input wire logic [7:0] oe_term_a,      // first port enable terms
  input wire logic       battery_route,  // battery routing
  input wire logic       battery_on_flag,// battery flag
  input wire logic       select_enable,  // select role on
  input wire logic       memory_disable, // decode off
  input wire logic       pd_counter_clk  // logic clock pulse
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  localparam logic [5:0] DOUT_A = 6'h01;
  localparam logic [7:0] FMASK  = io_port_pkg::FOURTH_MASK;
  wire logic rd_d = rd && addr[5:4] == io_port_pkg::PORT_FOURTH;
  logic [7:0] last_dout;
  // last accepted write to the first port data out register
  always_ff @(posedge clock)
  begin
    if (rst)
      last_dout <= 8'h00;
    else if (wr && addr == DOUT_A && !memory_disable)
      last_dout <= wdata;
  end
  sequence s_rd_dout;
    rd && addr == DOUT_A && !memory_disable;
  endsequence
  AST_DOUT_READBACK: assert property (
    s_rd_dout |=> rdata == $past(last_dout))
    else $error("data out read differs from write");
  AST_REFUSED_RD: assert property (
    rd && memory_disable |=> rdata == 8'h00)
    else $error("read served while decode disabled");
  AST_SELECT_OFF: assert property (
    select_enable && pin_d_in[2] |-> ##[1:2] memory_disable)
    else $error("select input did not disable decode");
  AST_OE_OR: assert property (
    !$past(rst) && !$past(rst, 2) && $past(oe_term_a) == $past(oe_term_a, 2)
    |-> (pin_a_oe & $past(oe_term_a)) == $past(oe_term_a))
    else $error("enable term did not turn driver on");
  AST_LOGIC_CLK: assert property (
    $rose(pin_d_in[1]) |-> ##[1:2] pd_counter_clk)
    else $error("logic clock edge not passed on");
  AST_CLK_PULSE: assert property (
    pd_counter_clk |=> !pd_counter_clk)
    else $error("counter clock pulse too long");
  AST_BATTERY: assert property (
    (battery_route && battery_on_flag) [*2] |=> pin_c_oe[4])
    else $error("battery indicator pin not driven");
  AST_D_PINS: assert property (
    (pin_d_oe & ~FMASK) == 8'h00)
    else $error("absent fourth port pin driven");
  AST_NO_CELL_D: assert property (
    rd_d && addr[3:0] inside {[4'h2:4'h5]} |=> rdata == 8'h00)
    else $error("fourth port cell register answered");
  AST_D_UNIMP: assert property (
    rd_d && addr[3:0] != 4'h0 |=> (rdata & ~FMASK) == 8'h00)
    else $error("unimplemented fourth port bit read back");
endmodule : io_port_assertions
bind io_port_path io_port_assertions chk (.*);

/* File: tb/pin_env.sv */
// pad model: resolves one port's pin levels from both drivers
`timescale 1ns/1ps
module pin_env (
  input  wire logic       clock,   // system clock
  input  wire logic [7:0] out_lvl, // device drive level
  input  wire logic [7:0] oe,      // device drive enable
  input  wire logic [7:0] ext,     // outside drive level
  input  wire logic       ext_en,  // outside party driving
  output logic      [7:0] pin      // resolved pad level
);
  logic [7:0] float_reg;
  // an undriven pad must not look stable
  always_ff @(posedge clock)
    float_reg <= (float_reg === 8'hAA) ? 8'h55 : 8'hAA;
  always_comb
    for (int i = 0; i < 8; i++)
      pin[i] = oe[i] ? out_lvl[i] : (ext_en ? ext[i] : float_reg[i]);
endmodule : pin_env

/* File: tb/io_port_path_tb_top.sv */
// self-checking bench for the four-port pin data path
`timescale 1ns/1ps
module io_port_path_tb_top;
  logic        clock, rst, wr, rd, ext_en;
  logic [5:0]  addr;
  logic [7:0]  wdata, rdata, pin_a_in, pin_b_in, pin_c_in, pin_d_in;
  logic [7:0]  pin_a_out, pin_b_out, pin_c_out, pin_d_out;
  logic [7:0]  pin_a_oe, pin_b_oe, pin_c_oe, pin_d_oe;
  logic [7:0]  pin_a_od, pin_b_od, pin_c_od, pin_a_fast, pin_b_fast;
  logic [7:0]  pin_d_fast, oe_term_a, oe_term_b, oe_term_c, oe_term_d;
  logic [7:0]  bank1_d, bank2_d, bank1_pins, bank2_pins, low_address;
  logic        bank1_to_b, bank2_to_c, periph_mode, periph_drive;
  logic [7:0]  periph_data, input_latch_en, bank1_q, bank2_q, ext_a;
  logic        battery_route, battery_on_flag, select_enable;
  logic        memory_disable, pd_counter_clk;
  logic [23:0] input_cell_bus;
  int          failures, checks_done;
  localparam logic [1:0] PA = io_port_pkg::PORT_FIRST;
  localparam logic [1:0] PB = io_port_pkg::PORT_SECOND;
  localparam logic [1:0] PC = io_port_pkg::PORT_THIRD;
  localparam logic [1:0] PD = io_port_pkg::PORT_FOURTH;

  io_port_path uut (.*);
  pin_env pa (.clock(clock), .out_lvl(pin_a_out), .oe(pin_a_oe),
    .ext(ext_a), .ext_en(ext_en), .pin(pin_a_in));
  pin_env pc (.clock(clock), .out_lvl(pin_c_out), .oe(pin_c_oe),
    .ext(8'h00), .ext_en(ext_en), .pin(pin_c_in));

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wreg(input logic [1:0] p, input logic [3:0] r,
                      input logic [7:0] d);
    @(posedge clock);
    addr <= {p, r};
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [1:0] p, input logic [3:0] r,
                      input logic [7:0] e);
    @(posedge clock);
    addr <= {p, r};
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rreg

  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask : settle

  task automatic t_reset;
    for (int p = 0; p < 3; p++)
    begin
      rreg(2'(p), 4'h3, 8'h00);
      rreg(2'(p), 4'h6, 8'h00);
    end
    rreg(PA, 4'h8, 8'h00);
    $display("reset test done");
  endtask : t_reset

  task automatic t_dout;
    ext_a <= 8'h5A;
    pin_b_in <= 8'hC3;
    wreg(PA, 4'h1, 8'hA5);
    rreg(PA, 4'h1, 8'hA5);
    rreg(PA, 4'h0, 8'h5A);
    rreg(PB, 4'h0, 8'hC3);
    wreg(PA, 4'h7, 8'hFF);
    settle;
    chk(pin_a_out, 8'hA5);
    rreg(PA, 4'h5, 8'hFF);
    wreg(PA, 4'h7, 8'h00);
    {oe_term_a, oe_term_b, oe_term_c, oe_term_d} <= 32'h0FF003FF;
    settle;
    chk(pin_a_oe, 8'h0F);
    chk(pin_a_out & 8'h0F, 8'h05);
    chk(pin_b_oe, 8'hF0);
    chk(pin_c_oe & 8'h0F, 8'h03);
    chk(pin_d_oe, 8'h06);
    rreg(PA, 4'h5, 8'h0F);
    {oe_term_a, oe_term_b, oe_term_c, oe_term_d} <= 32'h0;
    $display("data out test done");
  endtask : t_dout

  task automatic t_cells;
    int n;
    wreg(PA, 4'h3, 8'hF0);
    rreg(PA, 4'h3, 8'hF0);
    wreg(PA, 4'h2, 8'h3C);
    rreg(PA, 4'h2, 8'h0C);
    chk(bank1_q, 8'h0C);
    wreg(PA, 4'h3, 8'h00);
    {bank1_d, bank2_d} <= 16'h9681;
    pin_d_in[1] <= 1'b1;
    n = 0;
    while (bank1_q !== 8'h96 && n < 8)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    chk(bank1_q, 8'h96);
    chk(bank2_q, 8'h81);
    if (n == 8)
      end_sim;
    pin_d_in[1] <= 1'b0;
    rreg(PA, 4'h2, 8'h96);
    bank1_pins <= 8'h0F;
    settle;
    chk(pin_a_out, 8'hA6);
    bank1_pins <= 8'h00;
    {bank1_to_b, bank2_to_c} <= 2'b11;
    settle;
    rreg(PB, 4'h2, 8'h96);
    rreg(PC, 4'h2, 8'h81);
    {bank1_to_b, bank2_to_c} <= 2'b00;
    $display("cell test done");
  endtask : t_cells

  task automatic t_misc;
    input_latch_en <= 8'hFF;
    ext_a <= 8'h3C;
    settle;
    rreg(PA, 4'h4, 8'h3C);
    chk(input_cell_bus[7:0], 8'h3C);
    rreg(PD, 4'h4, 8'h00);
    wreg(PA, 4'h6, 8'hC3);
    wreg(PC, 4'h6, 8'hFF);
    wreg(PD, 4'h6, 8'hFF);
    settle;
    chk(pin_a_od, 8'hC0);
    chk(pin_a_fast, 8'h03);
    chk(pin_c_od, 8'hFF);
    chk(pin_d_fast, 8'h06);
    rreg(PD, 4'h6, 8'h06);
    wreg(PB, 4'h6, 8'h5A);
    wreg(PB, 4'h1, 8'h96);
    wreg(PC, 4'h1, 8'h2B);
    wreg(PD, 4'h1, 8'hFF);
    settle;
    chk(pin_b_od, 8'h50);
    chk(pin_b_fast, 8'h0A);
    chk(pin_b_out, 8'h96);
    chk(pin_c_out, 8'h2B);
    chk(pin_d_out, 8'h06);
    low_address <= 8'h7E;
    wreg(PA, 4'h8, 8'hFF);
    wreg(PA, 4'h7, 8'hFF);
    settle;
    chk(pin_a_out, 8'h7E);
    rreg(PA, 4'h8, 8'hFF);
    {periph_mode, periph_drive, periph_data} <= 10'h35C;
    settle;
    chk(pin_a_out, 8'h5C);
    chk(pin_a_oe, 8'hFF);
    periph_mode <= 1'b0;
    wreg(PC, 4'h8, 8'hFF);
    rreg(PC, 4'h8, 8'h00);
    $display("drive and mode test done");
  endtask : t_misc

  task automatic t_power;
    {select_enable, battery_route, battery_on_flag} <= 3'b111;
    pin_d_in[2] <= 1'b1;
    settle;
    chk({7'h00, memory_disable}, 8'h01);
    chk({7'h00, pin_c_out[4]}, 8'h01);
    wreg(PA, 4'h1, 8'h11);
    rreg(PA, 4'h1, 8'h00);
    pin_d_in[2] <= 1'b0;
    settle;
    rreg(PA, 4'h1, 8'hA5);
    {select_enable, battery_route, battery_on_flag} <= 3'b000;
    $display("select and battery test done");
  endtask : t_power

  initial
  begin
    #200000;
    failures++;
    end_sim;
  end

  initial
  begin
    rst = 1'b1;
    ext_en = 1'b1;
    {wr, rd, bank1_to_b, bank2_to_c, periph_mode, periph_drive} = '0;
    {battery_route, battery_on_flag, select_enable, addr, wdata} = '0;
    {pin_b_in, pin_d_in, oe_term_a, oe_term_b, oe_term_c} = '0;
    {oe_term_d, bank1_d, bank2_d, bank1_pins, bank2_pins} = '0;
    {low_address, periph_data, input_latch_en, ext_a} = '0;
    failures = 0;
    checks_done = 0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    t_reset;
    t_dout;
    t_cells;
    t_misc;
    t_power;
    end_sim;
  end
endmodule : io_port_path_tb_top
